// File: hdl/vicinity_ppm_rx.sv
`timescale 1ns/1ps
module vicinity_ppm_rx #(
  parameter int PWRUP_CYCLES = ppm_rx_pkg::PWRUP_CYC,
  parameter int TURN_CYCLES  = ppm_rx_pkg::TURN_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       carrierClk,
  input  wire logic       pauseIn,
  input  wire logic       respDone,
  output logic            rxReady,
  output logic [7:0]      rxData,
  output logic            rxValid,
  output logic            frameStart,
  output logic            frameEnd,
  output logic            frameError,
  output logic            codingQuarter
);

  // ----------------------------------------
  // Readiness timers
  // ----------------------------------------
  logic [15:0] pwrCnt_reg;
  logic [15:0] turnCnt_reg;
  logic        pwrDone;
  logic        turnDone;
  logic        ready_reg;

  localparam logic [15:0] CNT_ZERO = ppm_rx_pkg::CNT_RESET;
  assign pwrDone  = pwrCnt_reg == 16'(PWRUP_CYCLES);
  assign turnDone = turnCnt_reg == CNT_ZERO;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwrCnt_reg  <= ppm_rx_pkg::CNT_RESET;
      turnCnt_reg <= ppm_rx_pkg::CNT_RESET;
      ready_reg   <= 1'b0;
    end else begin
      if (!pwrDone) begin
        pwrCnt_reg <= pwrCnt_reg + 16'h0001;
      end
      if (respDone) begin
        turnCnt_reg <= 16'(TURN_CYCLES);
      end else if (!turnDone) begin
        turnCnt_reg <= turnCnt_reg - 16'h0001;
      end
      ready_reg <= pwrDone && turnDone && !respDone;
    end
  end

  assign rxReady = ready_reg;

  // ----------------------------------------
  // Crossings into the carrier domain
  // ----------------------------------------
  logic [1:0] rstSync;
  logic [1:0] readySync;
  logic [1:0] pauseSync;
  logic       pausePrev;
  logic       linkRst;

  always_ff @(posedge carrierClk) begin
    rstSync   <= {rstSync[0], rst};
    readySync <= {readySync[0], ready_reg};
    pauseSync <= {pauseSync[0], pauseIn};
    pausePrev <= pauseSync[1];
  end

  assign linkRst = rstSync[1];

  // ----------------------------------------
  // Pulse position decoder
  // ----------------------------------------
  ppm_rx_pkg::link_state_type state_reg;
  ppm_rx_pkg::link_state_type state_next;
  logic [6:0] phase_reg;
  logic [9:0] unit_reg;
  logic       quarter_reg;
  logic       seen_reg;
  logic [1:0] pairCnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] byte_reg;
  logic [3:0] evtTog_reg;
  logic [3:0] evtTog_next;

  logic       pauseEdge;
  logic       unitDone;
  logic [9:0] symUnits;
  logic       symEnd;
  logic [1:0] pairVal;
  logic [7:0] fullVal;
  logic [7:0] quadByte;
  logic       sofQuad;
  logic       sofFull;
  logic       sofDone;
  logic       eofDone;
  logic       oddUnit;

  // Pause edge is the rising edge of the demodulated level for either depth
  assign pauseEdge = pauseSync[1] && !pausePrev;
  assign unitDone  = phase_reg == ppm_rx_pkg::UNIT_LAST;
  assign symUnits  = quarter_reg ? ppm_rx_pkg::QUAD_UNITS : ppm_rx_pkg::FULL_UNITS;
  assign symEnd    = unitDone && unit_reg == symUnits - 10'h001;
  assign oddUnit   = unit_reg[0];
  assign pairVal   = unit_reg[2:1];
  assign fullVal   = unit_reg[8:1];
  assign quadByte  = {pairVal, shift_reg[7:2]};
  assign sofQuad   = unit_reg == ppm_rx_pkg::SOF_QUAD_POS;
  assign sofFull   = unit_reg == ppm_rx_pkg::SOF_FULL_POS;
  assign sofDone   = unitDone && unit_reg == ppm_rx_pkg::SOF_UNITS - 10'h001;
  assign eofDone   = unitDone && unit_reg == ppm_rx_pkg::EOF_UNITS - 10'h001;

  // Event toggles: 0 byte, 1 start, 2 end, 3 error
  always_comb begin
    state_next  = state_reg;
    evtTog_next = evtTog_reg;
    unique case (state_reg)
      ppm_rx_pkg::LINK_IDLE: begin
        if (pauseEdge && readySync[1]) begin
          state_next = ppm_rx_pkg::LINK_SOF;
        end
      end
      ppm_rx_pkg::LINK_SOF: begin
        if (pauseEdge && (seen_reg || !(sofQuad || sofFull))) begin
          state_next     = ppm_rx_pkg::LINK_IDLE;
          evtTog_next[3] = !evtTog_reg[3];
        end else if (sofDone) begin
          state_next     = seen_reg ? ppm_rx_pkg::LINK_DATA : ppm_rx_pkg::LINK_IDLE;
          evtTog_next[1] = evtTog_reg[1] ^ seen_reg;
          evtTog_next[3] = evtTog_reg[3] ^ !seen_reg;
        end
      end
      ppm_rx_pkg::LINK_DATA: begin
        if (pauseEdge && !oddUnit) begin
          // Even position cannot be data: only an end marker at unit 0 on a byte boundary
          if (unit_reg == 10'h000 && !seen_reg && pairCnt_reg == 2'b00) begin
            state_next = ppm_rx_pkg::LINK_EOF;
          end else begin
            state_next     = ppm_rx_pkg::LINK_IDLE;
            evtTog_next[3] = !evtTog_reg[3];
          end
        end else if (pauseEdge && seen_reg) begin
          state_next     = ppm_rx_pkg::LINK_IDLE;
          evtTog_next[3] = !evtTog_reg[3];
        end else if (pauseEdge) begin
          evtTog_next[0] = evtTog_reg[0] ^ (!quarter_reg || pairCnt_reg == 2'b11);
        end else if (symEnd && !seen_reg) begin
          state_next     = ppm_rx_pkg::LINK_IDLE;
          evtTog_next[3] = !evtTog_reg[3];
        end
      end
      ppm_rx_pkg::LINK_EOF: begin
        if (pauseEdge && (seen_reg || unit_reg != ppm_rx_pkg::EOF_POS)) begin
          state_next     = ppm_rx_pkg::LINK_IDLE;
          evtTog_next[3] = !evtTog_reg[3];
        end else if (eofDone) begin
          state_next     = ppm_rx_pkg::LINK_IDLE;
          evtTog_next[2] = evtTog_reg[2] ^ seen_reg;
          evtTog_next[3] = evtTog_reg[3] ^ !seen_reg;
        end
      end
    endcase
  end

  always_ff @(posedge carrierClk) begin
    if (linkRst) begin
      state_reg  <= ppm_rx_pkg::LINK_IDLE;
      evtTog_reg <= 4'h0;
    end else begin
      state_reg  <= state_next;
      evtTog_reg <= evtTog_next;
    end
  end

  always_ff @(posedge carrierClk) begin
    if (linkRst || state_reg == ppm_rx_pkg::LINK_IDLE) begin
      // Opening pause edge is cycle one of unit 0
      phase_reg <= {6'h00, pauseEdge && !linkRst};
      unit_reg  <= 10'h000;
    end else if (symEnd && state_reg == ppm_rx_pkg::LINK_DATA) begin
      phase_reg <= 7'h00;
      unit_reg  <= 10'h000;
    end else if (sofDone && state_reg == ppm_rx_pkg::LINK_SOF) begin
      phase_reg <= 7'h00;
      unit_reg  <= 10'h000;
    end else begin
      phase_reg <= phase_reg + 7'h01;
      unit_reg  <= unit_reg + {9'h000, unitDone};
    end
  end

  always_ff @(posedge carrierClk) begin
    if (linkRst || state_reg == ppm_rx_pkg::LINK_IDLE) begin
      seen_reg    <= 1'b0;
      pairCnt_reg <= 2'b00;
    end else if (pauseEdge) begin
      // End marker opener leaves its symbol empty
      seen_reg    <= state_reg != ppm_rx_pkg::LINK_DATA || oddUnit;
      pairCnt_reg <= pairCnt_reg + {1'b0, state_reg == ppm_rx_pkg::LINK_DATA && quarter_reg};
    end else if ((symEnd && state_reg == ppm_rx_pkg::LINK_DATA)
                 || (sofDone && state_reg == ppm_rx_pkg::LINK_SOF)) begin
      seen_reg    <= 1'b0;
    end
  end

  always_ff @(posedge carrierClk) begin
    if (linkRst) begin
      quarter_reg <= 1'b0;
      shift_reg   <= 8'h00;
      byte_reg    <= 8'h00;
    end else if (pauseEdge && state_reg == ppm_rx_pkg::LINK_SOF) begin
      quarter_reg <= sofQuad;
    end else if (pauseEdge && state_reg == ppm_rx_pkg::LINK_DATA && oddUnit) begin
      shift_reg <= quadByte;
      byte_reg  <= quarter_reg ? quadByte : fullVal;
    end
  end

  // ----------------------------------------
  // Events back into the system domain
  // ----------------------------------------
  logic [3:0] evtSync1;
  logic [3:0] evtSync2;
  logic [3:0] evtPrev;
  logic [3:0] evtHit;
  logic [7:0] rxData_reg;
  logic [3:0] pulse_reg;
  logic       quarterOut_reg;

  assign evtHit = evtSync2 ^ evtPrev;

  always_ff @(posedge clk_sys) begin
    evtSync1 <= evtTog_reg;
    evtSync2 <= evtSync1;
  end

  // Data is set on the same carrier edge as its toggle, mode long before; both are stable when the toggle arrives
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      evtPrev        <= 4'h0;
      pulse_reg      <= 4'h0;
      rxData_reg     <= 8'h00;
      quarterOut_reg <= 1'b0;
    end else begin
      evtPrev   <= evtSync2;
      pulse_reg <= evtHit;
      if (evtHit[0]) begin
        rxData_reg <= byte_reg;
      end
      if (evtHit[1]) begin
        quarterOut_reg <= quarter_reg;
      end
    end
  end

  assign rxData        = rxData_reg;
  assign rxValid       = pulse_reg[0];
  assign frameStart    = pulse_reg[1];
  assign frameEnd      = pulse_reg[2];
  assign frameError    = pulse_reg[3];
  assign codingQuarter = quarterOut_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence quadSof_s;
    state_reg == ppm_rx_pkg::LINK_SOF && pauseEdge && !seen_reg && sofQuad;
  endsequence

  sequence quarterSet_s;
    quarter_reg && state_reg == ppm_rx_pkg::LINK_SOF;
  endsequence

  power_wait_a: assert property (@(posedge clk_sys) $fell(rst) |-> !rxReady [*8])
    else $error("ready too early after power-up");

  turn_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
    respDone |=> !rxReady [*8])
    else $error("ready too early after response");

  unit_wrap_a: assert property (@(posedge carrierClk) disable iff (linkRst)
    state_reg == ppm_rx_pkg::LINK_DATA && unitDone && !symEnd && !pauseEdge
    |=> phase_reg == 7'h00 && unit_reg == $past(unit_reg) + 10'h001)
    else $error("half slot length wrong");

  quad_mode_a: assert property (@(posedge carrierClk) disable iff (linkRst)
    quadSof_s |=> quarterSet_s)
    else $error("1-of-4 start not recognised");

  sof_accept_a: assert property (@(posedge carrierClk) disable iff (linkRst)
    state_reg == ppm_rx_pkg::LINK_SOF && sofDone && seen_reg && !pauseEdge
    |=> state_reg == ppm_rx_pkg::LINK_DATA && evtTog_reg[1] != $past(evtTog_reg[1]))
    else $error("start of frame not accepted");

  full_byte_a: assert property (@(posedge carrierClk) disable iff (linkRst)
    state_reg == ppm_rx_pkg::LINK_DATA && pauseEdge && oddUnit && !seen_reg && !quarter_reg
    |=> byte_reg == $past(unit_reg[8:1]) && evtTog_reg[0] != $past(evtTog_reg[0]))
    else $error("1-of-256 value wrong");

  quad_byte_a: assert property (@(posedge carrierClk) disable iff (linkRst)
    state_reg == ppm_rx_pkg::LINK_DATA && pauseEdge && oddUnit && !seen_reg
    && quarter_reg && pairCnt_reg == 2'b11
    |=> byte_reg[7:6] == $past(unit_reg[2:1]) && byte_reg[5:0] == $past(shift_reg[7:2]))
    else $error("1-of-4 byte assembly wrong");

  end_mark_a: assert property (@(posedge carrierClk) disable iff (linkRst)
    state_reg == ppm_rx_pkg::LINK_EOF && eofDone && seen_reg
    |=> state_reg == ppm_rx_pkg::LINK_IDLE && evtTog_reg[2] != $past(evtTog_reg[2]))
    else $error("end of frame not signalled");

  violation_a: assert property (@(posedge carrierClk) disable iff (linkRst)
    state_reg == ppm_rx_pkg::LINK_DATA && pauseEdge && !oddUnit
    |=> state_reg inside {ppm_rx_pkg::LINK_EOF, ppm_rx_pkg::LINK_IDLE})
    else $error("even position taken as data");

  symbol_len_a: assert property (@(posedge carrierClk) disable iff (linkRst)
    state_reg == ppm_rx_pkg::LINK_DATA |-> unit_reg < symUnits)
    else $error("symbol overran its length");

  valid_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    rxValid |=> !rxValid)
    else $error("byte strobe longer than one cycle");

endmodule // vicinity_ppm_rx

// File: hdl/ppm_rx_pkg.sv
package ppm_rx_pkg;
  // ----------------------------------------
  // Carrier timing
  // ----------------------------------------
  localparam int          SLOT_CYC      = 256;
  localparam int          UNIT_CYC      = SLOT_CYC / 2;
  localparam logic [6:0]  UNIT_LAST     = 7'(UNIT_CYC - 1);
  localparam logic [9:0]  QUAD_UNITS    = 10'h008;
  localparam logic [9:0]  FULL_UNITS    = 10'h200;
  // ----------------------------------------
  // Delimiters, positions in half slots
  // ----------------------------------------
  localparam logic [9:0]  SOF_QUAD_POS  = 10'h005;
  localparam logic [9:0]  SOF_FULL_POS  = 10'h007;
  localparam logic [9:0]  SOF_UNITS     = 10'h008;
  localparam logic [9:0]  EOF_POS       = 10'h002;
  localparam logic [9:0]  EOF_UNITS     = 10'h004;
  // ----------------------------------------
  // Readiness times
  // ----------------------------------------
  localparam int          CLK_PERIOD_PS = 10000;
  localparam int          PWRUP_TIME_PS = 100000000;
  localparam int          TURN_TIME_PS  = 311500000;
  localparam int          PWRUP_CYC     = (PWRUP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          TURN_CYC      = (TURN_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [15:0] CNT_RESET     = 16'h0000;
  // ----------------------------------------
  // Receiver states
  // ----------------------------------------
  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_SOF  = 2'b01,
    LINK_DATA = 2'b11,
    LINK_EOF  = 2'b10
  } link_state_type;
endpackage

// File: bench/ppm_reader_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Reader side of the pause link
// ----------------------------------------
module ppm_reader_model (
  input  wire logic carrierClk,
  output logic      pauseIn
);
  localparam int PAUSE_CYC = 32;

  initial pauseIn = 1'b0;

  // Symbol of n half slots, pauses open units a and b
  task automatic symbol(input int n, input int a, input int b);
    for (int u = 0; u < n; u++) begin
      for (int c = 0; c < ppm_rx_pkg::UNIT_CYC; c++) begin
        @(posedge carrierClk);
        #1 pauseIn = ((u == a) || (u == b)) && (c < PAUSE_CYC);
      end
    end
  endtask

  task automatic send_sof(input logic quarter);
    symbol(8, 0, quarter ? 5 : 7);
  endtask

  task automatic send_pair(input logic [1:0] k);
    symbol(8, 2 * int'(k) + 1, -1);
  endtask

  task automatic send_byte(input logic [7:0] v);
    for (int i = 0; i < 4; i++) begin
      send_pair(v[2*i +: 2]);
    end
  endtask

  task automatic send_eof();
    symbol(4, 0, 2);
  endtask
endmodule // ppm_reader_model

// File: bench/vicinity_ppm_rx_bench.sv
`timescale 1ns/1ps
module vicinity_ppm_rx_bench;
  localparam int PWRUP = 20;
  localparam int TURN  = 30;

  logic       clk_sys;
  logic       carrierClk;
  logic       rst;
  logic       respDone;
  logic       pauseIn;
  logic       rxReady;
  logic [7:0] rxData;
  logic       rxValid;
  logic       frameStart;
  logic       frameEnd;
  logic       frameError;
  logic       codingQuarter;
  logic       modeSeen;
  logic [7:0] gotQ[$];
  int         errTotal = 0;
  int         numChecks = 0;
  int         startCnt, endCnt, failCnt;

  always #5 clk_sys = ~clk_sys;
  always #7.5 carrierClk = ~carrierClk;

  vicinity_ppm_rx #(.PWRUP_CYCLES(PWRUP), .TURN_CYCLES(TURN)) u_vicinity_ppm_rx (
    .clk_sys(clk_sys), .rst(rst), .carrierClk(carrierClk), .pauseIn(pauseIn), .respDone(respDone),
    .rxReady(rxReady), .rxData(rxData), .rxValid(rxValid), .frameStart(frameStart),
    .frameEnd(frameEnd), .frameError(frameError), .codingQuarter(codingQuarter));
  ppm_reader_model u_ppm_reader_model (.carrierClk(carrierClk), .pauseIn(pauseIn));

  // ----------------------------------------
  // Event log
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (rxValid === 1'b1) gotQ.push_back(rxData);
    if (frameStart === 1'b1) begin
      startCnt++;
      modeSeen = codingQuarter;
    end
    if (frameEnd === 1'b1) endCnt++;
    if (frameError === 1'b1) failCnt++;
  end

  task automatic check_bit(input string name, input logic exp, input logic got);
    numChecks++;
    if (got !== exp) begin
      $display("wrong value %s expected %b seen %b", name, exp, got);
      errTotal++;
    end
  endtask

  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    numChecks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      errTotal++;
    end
  endtask

  task automatic conclude();
    if (errTotal == 0 && numChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic clear_log();
    gotQ.delete();
    startCnt = 0;
    endCnt = 0;
    failCnt = 0;
    modeSeen = 1'bx;
  endtask

  task automatic do_reset();
    cycles(1);
    rst = 1'b1;
    cycles(10);
    rst = 1'b0;
    clear_log();
  endtask

  // Bounded wait for frame ends or errors and bytes
  task automatic wait_log(input int nEnd, input int nData);
    int k;
    for (k = 0; k < 2000; k++) begin
      if (endCnt + failCnt >= nEnd && gotQ.size() >= nData) break;
      cycles(1);
    end
    if (k == 2000) begin
      $display("wrong value wait expected event seen none");
      errTotal++;
      conclude();
    end
  endtask

  task automatic wait_ready();
    int k;
    for (k = 0; k < 400 && rxReady !== 1'b1; k++) cycles(1);
    if (k == 400) begin
      $display("wrong value rxReady expected 1 seen 0");
      errTotal++;
      conclude();
    end
    repeat (4) @(posedge carrierClk);
    clear_log();
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_powerup();
    do_reset();
    cycles(PWRUP - 2);
    check_bit("ready early", 1'b0, rxReady);
    cycles(7);
    check_bit("ready late", 1'b1, rxReady);
  endtask

  task automatic test_quarter();
    wait_ready();
    u_ppm_reader_model.send_sof(1'b1);
    u_ppm_reader_model.send_byte(8'he1);
    u_ppm_reader_model.send_byte(8'h1b);
    u_ppm_reader_model.send_eof();
    wait_log(1, 2);
    check_byte("starts", 8'h01, 8'(startCnt));
    check_bit("quarter mode", 1'b1, modeSeen);
    check_byte("bytes", 8'h02, 8'(gotQ.size()));
    check_byte("byte0", 8'he1, gotQ[0]);
    check_byte("byte1", 8'h1b, gotQ[1]);
    check_byte("ends", 8'h01, 8'(endCnt));
  endtask

  task automatic test_turn();
    respDone = 1'b1;
    cycles(1);
    respDone = 1'b0;
    cycles(1);
    check_bit("turn busy", 1'b0, rxReady);
    cycles(TURN - 4);
    check_bit("turn hold", 1'b0, rxReady);
    cycles(8);
    check_bit("turn ready", 1'b1, rxReady);
  endtask

  task automatic test_partial();
    wait_ready();
    u_ppm_reader_model.send_sof(1'b1);
    u_ppm_reader_model.send_pair(2'h2);
    u_ppm_reader_model.send_pair(2'h1);
    u_ppm_reader_model.send_eof();
    // Stray end pause opens a frame that then times out
    wait_log(2, 0);
    check_byte("errors", 8'h02, 8'(failCnt));
    check_byte("false ends", 8'h00, 8'(endCnt));
    check_byte("false bytes", 8'h00, 8'(gotQ.size()));
  endtask

  task automatic test_full();
    wait_ready();
    u_ppm_reader_model.send_sof(1'b0);
    u_ppm_reader_model.symbol(4, 1, -1);
    wait_log(0, 1);
    check_bit("full mode", 1'b0, modeSeen);
    check_byte("first slot", 8'h00, gotQ[0]);
    do_reset();
    cycles(2);
    check_bit("ready reset", 1'b0, rxReady);
  endtask

  initial begin
    clk_sys = 1'b0;
    carrierClk = 1'b0;
    rst = 1'b1;
    respDone = 1'b0;
    test_powerup();
    test_quarter();
    test_turn();
    test_partial();
    test_full();
    conclude();
  end
endmodule // vicinity_ppm_rx_bench
